// ==== logic/bit_sync.sv ====
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // async in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pulse_gen_pkg.sv ====
// shared constants for the configurable time pulse generator
package pulse_gen_pkg;

  // clock and time units
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned TICK_CYCLES = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [31:0] US_PER_SEC = 32'h000f4240;
  localparam logic [31:0] PCT_FULL = 32'h00000064;
  localparam logic [31:0] NS_PER_US_W = 32'h000003e8;

  // next-pulse report rate: one per second
  localparam int unsigned REPORT_PERIOD_MS = 1000;
  localparam int unsigned REPORT_CYCLES_DEF = REPORT_PERIOD_MS * (1000000 / CLK_PERIOD_NS);

  // time grid encoding
  typedef enum logic [2:0] {
    GRID_UTC = 3'h0,
    GRID_GPS = 3'h1,
    GRID_GLONASS = 3'h2,
    GRID_BEIDOU = 3'h3,
    GRID_GALILEO = 3'h4
  } time_grid_t;

  localparam int unsigned GRID_COUNT = 5;

  // utc variant encoding
  typedef enum logic [2:0] {
    UTC_AUTO = 3'h0,
    UTC_US = 3'h1,
    UTC_RUSSIAN = 3'h2,
    UTC_CHINESE = 3'h3,
    UTC_EUROPEAN = 3'h4
  } utc_variant_t;

  // bit positions in the constellation enable vector
  localparam int unsigned GNSS_GPS_BIT = 0;
  localparam int unsigned GNSS_GLONASS_BIT = 1;
  localparam int unsigned GNSS_BEIDOU_BIT = 2;
  localparam int unsigned GNSS_GALILEO_BIT = 3;

endpackage

// ==== logic/seq_div.sv ====
// free-running restoring unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
module seq_div #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // operands, sampled at the start of each pass
  input wire logic [WIDTH-1:0] num,
  input wire logic [WIDTH-1:0] den,
  // result
  output logic [WIDTH-1:0] quo,
  output logic done
);

  logic [WIDTH-1:0] num_ff;
  logic [WIDTH-1:0] den_ff;
  logic [WIDTH:0] rem_ff;
  logic [WIDTH-1:0] acc_ff;
  logic [$clog2(WIDTH+1)-1:0] cnt_ff;
  logic busy_ff;
  logic [WIDTH:0] nxt_rem;
  logic [WIDTH:0] trial;

  always_comb begin
    nxt_rem = {rem_ff[WIDTH-1:0], num_ff[WIDTH-1]};
    trial = nxt_rem - {1'b0, den_ff};
  end

  // restarts itself so results track operand changes within 2*WIDTH+1 cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      num_ff <= '0;
      den_ff <= '0;
      rem_ff <= '0;
      acc_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      quo <= '0;
      done <= 1'b0;
    end else if (!busy_ff) begin
      num_ff <= num;
      den_ff <= den;
      rem_ff <= '0;
      acc_ff <= '0;
      cnt_ff <= '0;
      busy_ff <= 1'b1;
      done <= 1'b0;
    end else begin
      num_ff <= {num_ff[WIDTH-2:0], 1'b0};
      if (!trial[WIDTH]) begin
        rem_ff <= trial;
        acc_ff <= {acc_ff[WIDTH-2:0], 1'b1};
      end else begin
        rem_ff <= nxt_rem;
        acc_ff <= {acc_ff[WIDTH-2:0], 1'b0};
      end
      cnt_ff <= cnt_ff + 1'b1;
      if (cnt_ff == ($clog2(WIDTH+1))'(WIDTH - 1)) begin
        busy_ff <= 1'b0;
        done <= 1'b1;
        // a zero divisor yields zero, which the generator treats as disabled
        quo <= (den_ff == '0) ? '0 : {acc_ff[WIDTH-2:0], ~trial[WIDTH]};
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/time_pulse_gen.sv ====
// configurable periodic time pulse generator aligned to a selectable time grid
`timescale 1ns/1ps
`default_nettype none
module time_pulse_gen
  import pulse_gen_pkg::*;
#(
  parameter int unsigned REPORT_CYCLES = REPORT_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pulse shape configuration
  input wire logic pulse_enable,
  input wire logic freq_type,
  input wire logic ratio_type,
  input wire logic [31:0] period_value,
  input wire logic [31:0] length_value,
  input wire logic [31:0] period_lock_value,
  input wire logic [31:0] length_lock_value,
  input wire logic use_locked,
  input wire logic polarity,
  // timing configuration
  input wire logic lock_to_gnss_freq,
  input wire logic align_to_second,
  input wire logic [2:0] time_grid_select,
  input wire logic signed [31:0] cable_delay_ns,
  input wire logic signed [31:0] user_delay_ns,
  input wire logic [2:0] utc_variant_select,
  input wire logic [3:0] gnss_enable,
  input wire logic wheel_tick_use_setting,
  // time solution status
  input wire logic time_valid,
  input wire logic utc_params_valid,
  // asynchronous reference pins
  input wire logic gnss_freq_ref,
  input wire logic [4:0] grid_second_mark,
  // pulse pin
  output logic first_pulse_output,
  output logic first_pulse_oe,
  // next pulse report and status
  output logic next_pulse_time_report,
  output logic [31:0] report_pulse_index,
  output logic [2:0] report_time_grid,
  output logic [2:0] input_pulse_grid,
  output logic [2:0] utc_variant_used
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] min_u32(input logic [31:0] a, input logic [31:0] b);
    min_u32 = (a < b) ? a : b;
  endfunction

  function automatic logic [31:0] abs_s32(input logic signed [31:0] v);
    abs_s32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect

  logic [5:0] pins_sync;
  logic [5:0] pins_d_ff;
  logic [5:0] pins_rise;

  bit_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({gnss_freq_ref, grid_second_mark}),
    .sync_out(pins_sync)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_d_ff <= '0;
    end else begin
      pins_d_ff <= pins_sync;
    end
  end

  assign pins_rise = pins_sync & ~pins_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick: local divider or recovered reference

  logic [$clog2(TICK_CYCLES)-1:0] local_div_ff;
  logic local_tick;
  logic tick;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      local_div_ff <= '0;
    end else if (local_div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      local_div_ff <= '0;
    end else begin
      local_div_ff <= local_div_ff + 1'b1;
    end
  end

  assign local_tick = (local_div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  // a stalled reference stops the pulse train rather than falling back silently
  assign tick = lock_to_gnss_freq ? pins_rise[5] : local_tick;

  ////////////////////////////////////////////////////////////////////////////
  // setting selection and period / width arithmetic

  logic locked_sel;
  logic [31:0] raw_per;
  logic [31:0] raw_len;
  logic [31:0] freq_quo;
  logic freq_done;
  logic [31:0] ratio_quo;
  logic ratio_done;
  logic [31:0] per_calc_ff;
  logic [31:0] len_calc_ff;
  logic [63:0] ratio_prod;

  assign locked_sel = use_locked & time_valid;
  assign raw_per = locked_sel ? period_lock_value : period_value;
  assign raw_len = locked_sel ? length_lock_value : length_value;

  seq_div #(
    .WIDTH(32)
  ) u_freq_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .num(US_PER_SEC),
    .den(raw_per),
    .quo(freq_quo),
    .done(freq_done)
  );

  // product is cut to 32 bits; periods above about 42 s in ratio mode wrap
  assign ratio_prod = per_calc_ff * raw_len;

  seq_div #(
    .WIDTH(32)
  ) u_ratio_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .num(ratio_prod[31:0]),
    .den(PCT_FULL),
    .quo(ratio_quo),
    .done(ratio_done)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_calc_ff <= '0;
    end else if (!freq_type) begin
      per_calc_ff <= raw_per;
    end else if (freq_done) begin
      per_calc_ff <= freq_quo;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      len_calc_ff <= '0;
    end else if (!ratio_type) begin
      len_calc_ff <= raw_len;
    end else if (ratio_done) begin
      len_calc_ff <= ratio_quo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay compensation and alignment

  logic signed [31:0] net_delay_us;
  logic [31:0] delay_mag;
  logic [31:0] align_load;
  logic [4:0] grid_onehot;
  logic grid_mark;
  logic align_now;

  // cable delay advances, user delay retards; resolution is one microsecond
  assign net_delay_us = (user_delay_ns - cable_delay_ns) / $signed(NS_PER_US_W);
  assign delay_mag = abs_s32(net_delay_us);

  always_comb begin
    if (delay_mag >= per_calc_ff || delay_mag == '0) begin
      align_load = '0;
    end else if (net_delay_us[31]) begin
      align_load = delay_mag;
    end else begin
      align_load = per_calc_ff - delay_mag;
    end
  end

  always_comb begin
    grid_onehot = '0;
    if (time_grid_select < 3'(GRID_COUNT)) begin
      grid_onehot[time_grid_select] = 1'b1;
    end
  end

  assign grid_mark = |(pins_rise[4:0] & grid_onehot);
  // the second marks of a grid only mean something once time is known
  assign align_now = align_to_second & time_valid & grid_mark;

  ////////////////////////////////////////////////////////////////////////////
  // period counter with boundary shadowing

  logic [31:0] cnt_ff;
  logic [31:0] per_act_ff;
  logic [31:0] len_act_ff;
  logic wrap;
  logic utc_seen_ff;
  logic withhold;
  logic gate;
  logic active;
  logic [31:0] pulse_cnt_ff;

  assign wrap = tick & (cnt_ff + 32'h00000001 >= per_act_ff);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (align_now) begin
      cnt_ff <= align_load;
    end else if (wrap || per_act_ff == '0) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 32'h00000001;
    end
  end

  // new settings load only at a period boundary, an alignment or while per_act_ff is zero, so apart from pulse_enable going low
  // or the UTC withhold only an alignment can cut a running pulse short
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_act_ff <= '0;
      len_act_ff <= '0;
    end else if (wrap || align_now || per_act_ff == '0) begin
      per_act_ff <= per_calc_ff;
      len_act_ff <= min_u32(len_calc_ff, per_calc_ff);
    end
  end

  // cold start is the reset; the flag stays until the next reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      utc_seen_ff <= 1'b0;
    end else if (utc_params_valid) begin
      utc_seen_ff <= 1'b1;
    end
  end

  assign withhold = (time_grid_select == GRID_UTC) & ~utc_seen_ff;
  assign gate = pulse_enable & ~withhold & (per_act_ff != '0);
  assign active = gate & (cnt_ff < len_act_ff);

  ////////////////////////////////////////////////////////////////////////////
  // output pin

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      first_pulse_output <= 1'b0;
      first_pulse_oe <= 1'b0;
    end else begin
      first_pulse_output <= active ? polarity : ~polarity;
      first_pulse_oe <= ~wheel_tick_use_setting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse counting and next pulse report

  logic [$clog2(REPORT_CYCLES)-1:0] rep_cnt_ff;
  logic rep_due;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_ff <= '0;
    end else if ((align_now ? (align_load == '0) : (wrap || per_act_ff == '0)) && pulse_enable
        && !withhold && per_calc_ff != '0 && len_calc_ff != '0) begin
      // counted as a pulse starts, so a report inside a pulse names the one after it
      pulse_cnt_ff <= pulse_cnt_ff + 32'h00000001;
    end
  end

  assign rep_due = (rep_cnt_ff == ($clog2(REPORT_CYCLES))'(REPORT_CYCLES - 1));

  // fixed rate, independent of the pulse rate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rep_cnt_ff <= '0;
    end else if (rep_due) begin
      rep_cnt_ff <= '0;
    end else begin
      rep_cnt_ff <= rep_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      next_pulse_time_report <= 1'b0;
      report_pulse_index <= '0;
      report_time_grid <= GRID_UTC;
    end else begin
      next_pulse_time_report <= rep_due;
      if (rep_due) begin
        report_pulse_index <= pulse_cnt_ff + 32'h00000001;
        report_time_grid <= time_grid_select;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input grid and utc variant

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_pulse_grid <= GRID_GPS;
    end else if (time_grid_select == GRID_UTC) begin
      input_pulse_grid <= GRID_GPS;
    end else begin
      input_pulse_grid <= time_grid_select;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      utc_variant_used <= UTC_AUTO;
    end else if (utc_variant_select != UTC_AUTO) begin
      utc_variant_used <= utc_variant_select;
    end else if (gnss_enable[GNSS_GPS_BIT]) begin
      utc_variant_used <= UTC_US;
    end else if (gnss_enable[GNSS_GLONASS_BIT]) begin
      utc_variant_used <= UTC_RUSSIAN;
    end else if (gnss_enable[GNSS_BEIDOU_BIT]) begin
      utc_variant_used <= UTC_CHINESE;
    end else if (gnss_enable[GNSS_GALILEO_BIT]) begin
      utc_variant_used <= UTC_EUROPEAN;
    end else begin
      utc_variant_used <= UTC_AUTO;
    end
  end

endmodule
`default_nettype wire

// ==== sim/pulse_sink.sv ====
// consumer of the time pulse: measures active time and period in clock cycles
`timescale 1ns/1ps
`default_nettype none
module pulse_sink (
  // clock
  input wire logic clk_sys,
  // pin and the level that counts as active
  input wire logic pin,
  input wire logic active_high,
  // measurements
  output logic [31:0] act_cyc,
  output logic [31:0] per_cyc,
  output logic [31:0] lead_cnt
);
  logic prev_ff = 1'b0;
  logic [31:0] run_ff = 32'h0;
  logic [31:0] since_ff = 32'h0;
  logic [31:0] act_ff = 32'h0;
  logic [31:0] per_ff = 32'h0;
  logic [31:0] lead_ff = 32'h0;
  assign act_cyc = act_ff;
  assign per_cyc = per_ff;
  assign lead_cnt = lead_ff;
  // a released pin reads as the pull-up level, like any other level
  always @(posedge clk_sys) begin
    prev_ff <= pin;
    since_ff <= since_ff + 32'h1;
    if (pin == active_high && prev_ff != active_high) begin // leading edge
      per_ff <= since_ff;
      since_ff <= 32'h1;
      lead_ff <= lead_ff + 32'h1;
      run_ff <= 32'h1;
    end else if (pin == active_high) begin
      run_ff <= run_ff + 32'h1;
    end else if (prev_ff == active_high) begin // trailing edge closes the width
      act_ff <= run_ff;
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_time_pulse_gen.sv ====
// self-checking bench for the time pulse generator
`timescale 1ns/1ps
`default_nettype none
module test_time_pulse_gen;
  // report spacing shortened from one second to keep the run short
  localparam int unsigned REP = 200;
  logic clk_sys = 1'b0, rst_n = 1'b0, pulse_enable = 1'b0, freq_type = 1'b0;
  logic ratio_type = 1'b0, use_locked = 1'b0, polarity = 1'b1, lock_freq = 1'b0;
  logic align = 1'b0, wheel = 1'b0, time_valid = 1'b0, utc_ok = 1'b0;
  logic ref_clk = 1'b0, ref_run = 1'b0;
  logic [31:0] per_v = 32'h3, len_v = 32'h1, per_l = 32'h0, len_l = 32'h0;
  logic [31:0] seed = 32'hcdae;
  logic [2:0] grid = 3'h0, uvar = 3'h0;
  logic [3:0] gen = 4'hf;
  logic [4:0] mark = 5'h0;
  logic signed [31:0] cable = 32'sh0, udly = 32'sh0;
  logic signed [31:0] cab_t [3] = '{32'sh0, 32'sh7d0, 32'sh1f4};
  logic signed [31:0] usr_t [3] = '{32'shbb8, 32'sh0, 32'sh1af4};
  int ex_t [3] = '{3, 8, 6};
  wire fp_out, fp_oe, rep;
  wire [2:0] rep_grid, in_grid, uvar_used;
  wire [31:0] act_cyc, per_cyc, lead_cnt, rep_idx;
  tri1 pin;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  assign pin = fp_oe ? fp_out : 1'bz;
  always #5 clk_sys = ~clk_sys;
  always #300 ref_clk = ref_run ? ~ref_clk : 1'b0;
  time_pulse_gen #(.REPORT_CYCLES(REP)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .pulse_enable(pulse_enable), .freq_type(freq_type),
    .ratio_type(ratio_type), .period_value(per_v), .length_value(len_v),
    .period_lock_value(per_l), .length_lock_value(len_l), .use_locked(use_locked),
    .polarity(polarity), .lock_to_gnss_freq(lock_freq), .align_to_second(align),
    .time_grid_select(grid), .cable_delay_ns(cable), .user_delay_ns(udly),
    .utc_variant_select(uvar), .gnss_enable(gen), .wheel_tick_use_setting(wheel),
    .time_valid(time_valid), .utc_params_valid(utc_ok), .gnss_freq_ref(ref_clk),
    .grid_second_mark(mark), .first_pulse_output(fp_out), .first_pulse_oe(fp_oe),
    .next_pulse_time_report(rep), .report_pulse_index(rep_idx), .report_time_grid(rep_grid),
    .input_pulse_grid(in_grid), .utc_variant_used(uvar_used)
  );
  pulse_sink i_sink (.clk_sys(clk_sys), .pin(pin), .active_high(polarity),
    .act_cyc(act_cyc), .per_cyc(per_cyc), .lead_cnt(lead_cnt));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [2:0] exp_var(input logic [2:0] s, input logic [3:0] e);
    if (s != 3'h0) return s;
    for (int b = 0; b < 4; b++) if (e[b]) return 3'(b + 1);
    return 3'h0;
  endfunction
  task automatic cmp_exact(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_range(input logic [31:0] got, input int exp, input int tol);
    cmp_count++;
    if ((got >= exp - tol && got <= exp + tol) !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_leads(input int n);
    logic [31:0] s = lead_cnt;
    int k = 0;
    while (lead_cnt - s < n && k < 12000) begin
      @(negedge clk_sys);
      k++;
    end
    // a pulse train that never arrives is a failure, not a stale measurement
    if (k == 12000) cmp_exact(lead_cnt - s, 32'(n));
  endtask
  // four leading edges so a half-applied setting never gets measured
  task automatic shape(input int p, input int a, input int tol);
    wait_leads(4);
    cmp_range(per_cyc, p, tol);
    cmp_range(act_cyc, a, tol);
  endtask
  task automatic stalled(input int n);
    logic [31:0] s;
    repeat (n) @(negedge clk_sys);
    s = lead_cnt;
    repeat (n) @(negedge clk_sys);
    cmp_exact(lead_cnt, s);
  endtask
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    int p;
    int l;
    int t0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    pulse_enable = 1'b1;
    stalled(400);
    cmp_exact(rep_idx, 32'h1);
    utc_ok = 1'b1;
    @(negedge clk_sys);
    utc_ok = 1'b0;
    shape(300, 100, 2);
    grid = 3'h1;
    for (int i = 0; i < 6; i++) begin
      p = 2 + xs() % 8;
      l = 1 + xs() % (p - 1);
      polarity = 1'(xs() % 2);
      per_v = 32'(p);
      len_v = 32'(l);
      shape(p * 100, l * 100, 2);
    end
    polarity = 1'b1;
    freq_type = 1'b1;
    ratio_type = 1'b1;
    per_v = 32'h3d090;
    len_v = 32'h19;
    shape(400, 100, 2);
    freq_type = 1'b0;
    per_v = 32'h5;
    len_v = 32'h28;
    shape(500, 200, 2);
    ratio_type = 1'b0;
    per_v = 32'h4;
    len_v = 32'h9;
    repeat (900) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (50) @(negedge clk_sys);
      cmp_exact({31'h0, pin}, 32'h1);
    end
    per_v = 32'h6;
    len_v = 32'h3;
    per_l = 32'h2;
    len_l = 32'h1;
    use_locked = 1'b1;
    shape(600, 300, 2);
    time_valid = 1'b1;
    shape(200, 100, 2);
    per_l = 32'h0;
    stalled(700);
    time_valid = 1'b0;
    shape(600, 300, 2);
    use_locked = 1'b0;
    pulse_enable = 1'b0;
    stalled(500);
    pulse_enable = 1'b1;
    wheel = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp_exact({31'h0, fp_oe}, 32'h0);
    cmp_exact({31'h0, pin}, 32'h1);
    wheel = 1'b0;
    ref_run = 1'b1;
    lock_freq = 1'b1;
    per_v = 32'h4;
    len_v = 32'h1;
    shape(240, 60, 4);
    lock_freq = 1'b0;
    ref_run = 1'b0;
    per_v = 32'ha;
    len_v = 32'h2;
    time_valid = 1'b1;
    align = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cable = cab_t[i];
      udly = usr_t[i];
      repeat (1100) @(negedge clk_sys);
      mark[1] = 1'b1;
      t0 = cyc;
      repeat (10) @(negedge clk_sys);
      mark[1] = 1'b0;
      wait_leads(1);
      cmp_range(32'(cyc - t0), ex_t[i] * 100 - 40, 65);
    end
    // pulse rate matched to the report rate, so each report window holds one pulse
    per_v = 32'h2;
    len_v = 32'h1;
    wait_leads(2);
    p = int'(rep_idx);
    for (int g = 0; g < 5; g++) begin
      grid = 3'(g);
      repeat (2 * REP) @(negedge clk_sys);
      cmp_exact({29'h0, rep_grid}, 32'(g));
      cmp_exact({29'h0, in_grid}, (g == 0) ? 32'h1 : 32'(g));
    end
    cmp_exact(rep_idx - 32'(p), 32'ha);
    for (int i = 0; i < 12; i++) begin
      uvar = (i < 5) ? 3'h0 : 3'(xs() % 5);
      gen = (i < 5) ? 4'(5'h10 >> (i + 1)) : 4'(xs());
      repeat (3) @(negedge clk_sys);
      cmp_exact({29'h0, uvar_used}, {29'h0, exp_var(uvar, gen)});
    end
    test_done();
  end
endmodule
`default_nettype wire

// ==== sim/time_pulse_gen_checker.sv ====
// port assertions for the time pulse generator
`timescale 1ns/1ps
`default_nettype none
module time_pulse_gen_checker #(
  parameter int unsigned REPORT_CYCLES = 200
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched inputs
  input wire logic pulse_enable,
  input wire logic polarity,
  input wire logic [2:0] time_grid_select,
  input wire logic wheel_tick_use_setting,
  input wire logic utc_params_valid,
  // watched outputs
  input wire logic first_pulse_output,
  input wire logic first_pulse_oe,
  input wire logic next_pulse_time_report,
  input wire logic [2:0] report_time_grid,
  input wire logic [2:0] input_pulse_grid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [1:0] up_ff;
  logic utc_seen_ff;
  logic rep_seen_ff;
  logic [31:0] gap_ff;
  ////////////////////////////////////////////////////////////
  // registered outputs still show reset values at the first edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      utc_seen_ff <= 1'b0;
    end else begin
      utc_seen_ff <= utc_seen_ff | utc_params_valid;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 32'h0;
      rep_seen_ff <= 1'b0;
    end else if (next_pulse_time_report) begin
      gap_ff <= 32'h1;
      rep_seen_ff <= 1'b1;
    end else begin
      gap_ff <= gap_ff + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence off_s;
    !pulse_enable ##1 (!pulse_enable && up_ff == 2'h3);
  endsequence
  sequence utc_wait_s;
    (time_grid_select == 3'h0) ##1
      (time_grid_select == 3'h0 && !utc_seen_ff && !utc_params_valid && up_ff == 2'h3);
  endsequence
  idle_when_off_a: assert property (off_s |=> first_pulse_output == !$past(polarity))
    else $error("pulse output active while disabled");
  utc_withheld_a: assert property (utc_wait_s |=> first_pulse_output == !$past(polarity))
    else $error("pulse output before utc data");
  oe_change_a: assert property ($changed(wheel_tick_use_setting) |=>
    first_pulse_oe == !$past(wheel_tick_use_setting)) else $error("pin enable missed change");
  oe_steady_a: assert property (up_ff == 2'h3 && $stable(wheel_tick_use_setting) |->
    first_pulse_oe == !wheel_tick_use_setting) else $error("pin enable wrong");
  grid_input_a: assert property (up_ff == 2'h3 |-> input_pulse_grid ==
    ($past(time_grid_select) == 3'h0 ? 3'h1 : $past(time_grid_select)))
    else $error("input pulse grid wrong");
  report_grid_a: assert property (next_pulse_time_report |->
    report_time_grid == $past(time_grid_select)) else $error("report grid wrong");
  report_gap_a: assert property (next_pulse_time_report && rep_seen_ff |->
    gap_ff == REPORT_CYCLES) else $error("report spacing wrong");
  report_pulse_a: assert property (next_pulse_time_report |=> !next_pulse_time_report)
    else $error("report longer than one cycle");
endmodule
bind time_pulse_gen time_pulse_gen_checker #(.REPORT_CYCLES(REPORT_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .pulse_enable(pulse_enable), .polarity(polarity),
  .time_grid_select(time_grid_select), .wheel_tick_use_setting(wheel_tick_use_setting),
  .utc_params_valid(utc_params_valid), .first_pulse_output(first_pulse_output),
  .first_pulse_oe(first_pulse_oe), .next_pulse_time_report(next_pulse_time_report),
  .report_time_grid(report_time_grid), .input_pulse_grid(input_pulse_grid)
);
`default_nettype wire
